// ===== logic/adccr_clkdiv.sv
// converter clock divider: one-cycle tick per divided clock
// assumes the converter input clock arrives as a tick on i_clk
`timescale 1ns/100ps
`include "adccr_consts.svh"
module adccr_clkdiv (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_src_tick,
   input wire logic [2:0] i_div_code,
   output logic o_tick
);
   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } adccr_div_st_t;
   adccr_div_st_t s_q;
   adccr_div_st_t s_d;
   logic [4:0] lim;
   always_comb begin
      // divide by 2 to the code, codes above 101 act as 101
      lim = 5'h1f;
      if (i_div_code <= 3'h5) begin
         lim = 5'((6'h01 << i_div_code) - 6'h01);
      end
      s_d = s_q;
      s_d.tick = 1'b0;
      if (i_src_tick) begin
         if (s_q.cnt >= lim) begin
            s_d.cnt = 5'h00;
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 5'h01;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign o_tick = s_q.tick;
endmodule

// ===== logic/adccr_consts.svh
// constants for the converter control register block
// assumes inclusion by bare name from the modules
`ifndef ADCCR_CONSTS_SVH
`define ADCCR_CONSTS_SVH
`define ADCCR_CTRL_OFS 8'h00
`define ADCCR_STAT_OFS 8'h04
`define ADCCR_CLKDIV_MSB 12
`define ADCCR_CLKDIV_LSB 10
`define ADCCR_ACQ_MSB 9
`define ADCCR_ACQ_LSB 8
`define ADCCR_START_BIT 7
`define ADCCR_PWR_BIT 5
`define ADCCR_MODE_MSB 4
`define ADCCR_MODE_LSB 3
`define ADCCR_TRIG_MSB 2
`define ADCCR_TRIG_LSB 0
`define ADCCR_WMASK 16'h1fbf
`define ADCCR_CTRL_RST 16'h0600
`define ADCCR_PWRUP_NS 5000
`define ADCCR_CLK_MHZ 125
`define ADCCR_CONV_CLKS 14
`endif

// ===== logic/adccr_pkg.sv
// types for the converter control register block
// assumes the constants header sits beside it
package adccr_pkg;
   typedef enum logic [2:0] {
      ADCCR_TRIG_PIN = 3'b000,
      ADCCR_TRIG_TMR1 = 3'b001,
      ADCCR_TRIG_TMR0 = 3'b010,
      ADCCR_TRIG_SINGLE = 3'b011,
      ADCCR_TRIG_CONT = 3'b100,
      ADCCR_TRIG_PLA = 3'b101
   } adccr_trig_t;
   typedef enum logic [1:0] {
      ADCCR_IDLE = 2'b00,
      ADCCR_ACQ = 2'b01,
      ADCCR_CONV = 2'b10
   } adccr_state_t;
endpackage

// ===== logic/adccr_top.sv
// converter control register, trigger selection and sequencing
// assumes a plain register port and trigger pulses on i_clk except the start pin
// Behaviour
// - The converter clock is the input clock divided by 1 to 32 per bits 12:10, default /2.
// - Acquisition lasts 2, 4, 8 or 16 converter clocks per bits 9:8, default 8.
// - Bit 7 set lets any trigger start a conversion while bit 5 is set, clear blocks new starts.
// - Clearing bit 7 does not stop continuous conversion already running.
// - Bit 5 powers the converter up or down, and results count only 5 us after power-up.
// - Bits 2:0 pick pin, timer one, timer zero, single, continuous or logic-array trigger.
// - A finished single software conversion rewrites the trigger field to 000.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "adccr_consts.svh"
module adccr_top #(
   parameter int unsigned PWRUP_CYCLES = (`ADCCR_PWRUP_NS * `ADCCR_CLK_MHZ + 999) / 1000,
   parameter int unsigned CONV_CLKS = `ADCCR_CONV_CLKS
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_converter_input_clock_tick,
   input wire logic i_external_conversion_trigger_pin,
   input wire logic i_timer1_trig,
   input wire logic i_timer0_trig,
   input wire logic i_programmable_logic_array_trig,
   output logic o_adc_power,
   output logic o_adc_ready,
   output logic [1:0] o_conv_mode,
   output logic o_busy,
   output logic o_sample,
   output logic o_conv_done
);
   localparam int unsigned PW_W = $clog2(PWRUP_CYCLES + 1);
   if (PWRUP_CYCLES < 1 || CONV_CLKS < 1 || CONV_CLKS > 255) begin : g_bad_param
      $error("adccr_top: bad parameter");
   end
   typedef struct packed {
      logic [15:0] ctrl;
      adccr_pkg::adccr_state_t st;
      logic [7:0] cnt;
      logic cont_run;
      logic [PW_W-1:0] pw;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
      logic [15:0] rdata;
      logic done;
   } adccr_st_t;
   adccr_st_t s_q;
   adccr_st_t s_d;
   logic cclk_tick;
   logic pin_rise;
   logic trig;
   logic [7:0] acq_len;
   logic [2:0] tsel;

   // converter clock from bits 12:10
   // divided clock tick
   adccr_clkdiv u_div (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_src_tick(i_converter_input_clock_tick),
      .i_div_code(s_q.ctrl[`ADCCR_CLKDIV_MSB:`ADCCR_CLKDIV_LSB]),
      .o_tick(cclk_tick)
   );

   always_comb begin
      tsel = s_q.ctrl[`ADCCR_TRIG_MSB:`ADCCR_TRIG_LSB];
      pin_rise = s_q.pin_s2 & ~s_q.pin_s3;
      acq_len = 8'h02 << s_q.ctrl[`ADCCR_ACQ_MSB:`ADCCR_ACQ_LSB];
      unique case (tsel)
         adccr_pkg::ADCCR_TRIG_PIN: trig = pin_rise;
         adccr_pkg::ADCCR_TRIG_TMR1: trig = i_timer1_trig;
         adccr_pkg::ADCCR_TRIG_TMR0: trig = i_timer0_trig;
         adccr_pkg::ADCCR_TRIG_SINGLE: trig = 1'b1;
         adccr_pkg::ADCCR_TRIG_CONT: trig = 1'b1;
         adccr_pkg::ADCCR_TRIG_PLA: trig = i_programmable_logic_array_trig;
         default: trig = 1'b0;
      endcase
      s_d = s_q;
      s_d.pin_s1 = i_external_conversion_trigger_pin;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;
      s_d.done = 1'b0;
      if (!s_q.ctrl[`ADCCR_PWR_BIT]) begin
         s_d.pw = '0;
      end else if (s_q.pw != PW_W'(PWRUP_CYCLES)) begin
         s_d.pw = s_q.pw + PW_W'(1);
      end
      unique case (s_q.st)
         adccr_pkg::ADCCR_IDLE: begin
            if (s_q.ctrl[`ADCCR_PWR_BIT] && trig &&
                (s_q.ctrl[`ADCCR_START_BIT] ||
                 (s_q.cont_run && tsel == adccr_pkg::ADCCR_TRIG_CONT))) begin
               s_d.st = adccr_pkg::ADCCR_ACQ;
               s_d.cnt = 8'h00;
               s_d.cont_run = (tsel == adccr_pkg::ADCCR_TRIG_CONT);
            end
         end
         adccr_pkg::ADCCR_ACQ: begin
            if (cclk_tick) begin
               if (s_q.cnt == acq_len - 8'h01) begin
                  s_d.st = adccr_pkg::ADCCR_CONV;
                  s_d.cnt = 8'h00;
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
         adccr_pkg::ADCCR_CONV: begin
            if (cclk_tick) begin
               if (s_q.cnt == 8'(CONV_CLKS - 1)) begin
                  s_d.st = adccr_pkg::ADCCR_IDLE;
                  s_d.done = 1'b1;
                  if (tsel == adccr_pkg::ADCCR_TRIG_SINGLE) begin
                     s_d.ctrl[`ADCCR_TRIG_MSB:`ADCCR_TRIG_LSB] = 3'b000;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
         default: s_d.st = adccr_pkg::ADCCR_IDLE;
      endcase
      if (tsel != adccr_pkg::ADCCR_TRIG_CONT || !s_q.ctrl[`ADCCR_PWR_BIT]) begin
         s_d.cont_run = 1'b0;
      end
      if (i_wr && i_addr == `ADCCR_CTRL_OFS) begin
         s_d.ctrl = i_wdata & `ADCCR_WMASK;
         if (i_wdata[`ADCCR_TRIG_MSB:`ADCCR_TRIG_LSB] != 3'(adccr_pkg::ADCCR_TRIG_CONT)) begin
            s_d.cont_run = 1'b0;
         end
      end
      s_d.rdata = 16'h0000;
      if (i_rd) begin
         if (i_addr == `ADCCR_CTRL_OFS) begin
            s_d.rdata = s_q.ctrl;
         end else if (i_addr == `ADCCR_STAT_OFS) begin
            s_d.rdata = {12'h000, s_q.cont_run, o_adc_ready, o_busy, s_q.ctrl[`ADCCR_PWR_BIT]};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
         s_q.ctrl <= `ADCCR_CTRL_RST;
         s_q.st <= adccr_pkg::ADCCR_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_adc_power = s_q.ctrl[`ADCCR_PWR_BIT];
   assign o_adc_ready = s_q.ctrl[`ADCCR_PWR_BIT] && (s_q.pw == PW_W'(PWRUP_CYCLES));
   assign o_conv_mode = s_q.ctrl[`ADCCR_MODE_MSB:`ADCCR_MODE_LSB];
   assign o_busy = (s_q.st != adccr_pkg::ADCCR_IDLE);
   assign o_sample = (s_q.st == adccr_pkg::ADCCR_ACQ);
   assign o_conv_done = s_q.done;

   property p_resv_zero;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_q.ctrl[15:13] == 3'b000) && !s_q.ctrl[6];
   endproperty
   a_resv_zero: assert property (p_resv_zero) else $error("reserved bits set");
   property p_start_gate;
      @(posedge i_clk) disable iff (i_sys_rst)
      (!o_busy && !s_q.ctrl[`ADCCR_START_BIT] && !s_q.cont_run) |=> !o_busy;
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("start while disabled");
   property p_single_clear;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_q.done && !$past(i_wr) && $past(tsel) == 3'b011) |-> tsel == 3'b000;
   endproperty
   a_single_clear: assert property (p_single_clear) else $error("single not cleared");
   property p_pwr_off_ready;
      @(posedge i_clk) disable iff (i_sys_rst)
      !o_adc_power |-> !o_adc_ready;
   endproperty
   a_pwr_off_ready: assert property (p_pwr_off_ready) else $error("ready while off");
   property p_acq_min;
      @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_sample) |-> o_sample [*2];
   endproperty
   a_acq_min: assert property (p_acq_min) else $error("acquisition too short");
   property p_reset_val;
      @(posedge i_clk) $fell(i_sys_rst) |-> s_q.ctrl == `ADCCR_CTRL_RST;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("bad reset value");
   property p_cont_keep;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_q.cont_run && s_q.done && !i_wr && o_adc_power && tsel == 3'b100) |=> o_busy;
   endproperty
   a_cont_keep: assert property (p_cont_keep) else $error("continuous halted");
   property p_bad_trig;
      @(posedge i_clk) disable iff (i_sys_rst)
      (!o_busy && tsel > 3'b101) |=> !o_busy;
   endproperty
   a_bad_trig: assert property (p_bad_trig) else $error("reserved trigger started");
   property p_rd_resv;
      @(posedge i_clk) disable iff (i_sys_rst)
      $past(i_rd) |-> (o_rdata[15:13] == 3'b000) && !o_rdata[6];
   endproperty
   a_rd_resv: assert property (p_rd_resv) else $error("reserved read bits set");
   property p_pwr_start;
      @(posedge i_clk) disable iff (i_sys_rst)
      (!o_adc_power && !o_busy) |=> !o_busy;
   endproperty
   a_pwr_start: assert property (p_pwr_start) else $error("start while powered down");
endmodule

// ===== tb/adccr_src_model.sv
// converter clock source and trigger sources for the control block
// assumes all outputs are sampled on i_clk
`timescale 1ns/100ps
module adccr_src_model (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic [3:0] i_fire,
   output logic o_tick,
   output logic o_pin,
   output logic [2:0] o_trig
);
   logic ph = 1'b0;
   logic [1:0] pin_cnt = 2'd0;
   always @(posedge i_clk) begin
      ph <= ~ph;
      if (i_fire[0]) pin_cnt <= 2'd3;
      else if (pin_cnt != 2'd0) pin_cnt <= pin_cnt - 2'd1;
   end
   assign o_tick = i_slow ? ph : 1'b1;
   assign o_pin = (pin_cnt != 2'd0);
   assign o_trig = i_fire[3:1];
endmodule

// ===== tb/adccr_top_test.sv
// self-checking bench for the converter control register block
// assumes shortened power-up and conversion counts
`timescale 1ns/100ps
module adccr_top_test;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic slow = 1'b0;
   logic [3:0] fire = 4'h0;
   logic [15:0] o_rdata;
   logic tick, pin, busy, smp, done, pwr, rdy;
   logic [2:0] trg;
   logic [1:0] mode;
   logic rd_d = 1'b0;
   logic [15:0] exp_q[$];
   int fail_count = 0;
   int checks_done = 0;
   int n;
   bit got;
   logic [15:0] r;
   always #4 i_clk = ~i_clk;
   adccr_src_model i_src (.i_clk(i_clk), .i_slow(slow), .i_fire(fire), .o_tick(tick),
      .o_pin(pin), .o_trig(trg));
   adccr_top #(.PWRUP_CYCLES(4), .CONV_CLKS(4)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_converter_input_clock_tick(tick), .i_external_conversion_trigger_pin(pin),
      .i_timer1_trig(trg[0]), .i_timer0_trig(trg[1]), .i_programmable_logic_array_trig(trg[2]),
      .o_adc_power(pwr), .o_adc_ready(rdy), .o_conv_mode(mode), .o_busy(busy),
      .o_sample(smp), .o_conv_done(done));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wrap_up();
      $display("checks=%0d fails=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      i_addr <= a;
      i_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask
   task pulse(input logic [3:0] f);
      fire <= f;
      @(posedge i_clk);
      fire <= 4'h0;
   endtask
   task wbusy();
      got = 1'b0;
      repeat (8) begin
         @(posedge i_clk);
         if (busy === 1'b1) got = 1'b1;
      end
   endtask
   task wdone();
      int k;
      k = 0;
      n = 0;
      while (done !== 1'b1 && k < 3000) begin
         @(posedge i_clk);
         k++;
         if (smp === 1'b1) n++;
      end
      chk({15'h0, k < 3000}, 16'h0001);
   endtask
   task single(input logic [2:0] dv, input logic [1:0] aq, input bit s);
      int p, len;
      p = (1 << dv) * (s ? 2 : 1);
      len = 2 << aq;
      slow <= s;
      wr(8'h00, {3'b000, dv, aq, 8'ha3});
      wdone();
      chk({15'h0, n >= (len - 1) * p && n <= len * p + 1}, 16'h0001);
      rd(8'h00, {3'b000, dv, aq, 8'ha0});
   endtask
   // read data checked the cycle after the strobe
   always @(posedge i_clk) begin
      if (rd_d) chk(o_rdata, exp_q.pop_front());
      rd_d <= i_rd;
   end
   initial begin
      repeat (80000) @(posedge i_clk);
      fail_count++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h7e3f));
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      rd(8'h00, 16'h0600);
      wr(8'h0c, 16'h1234);
      rd(8'h08, 16'h0000);
      @(posedge i_clk);
      rd(8'h00, 16'h0600);
      $display("test reset done");
      r = 16'($urandom);
      r[2:0] = 3'b110;
      wr(8'h00, r);
      rd(8'h00, r & 16'h1fbf);
      chk({14'h0, mode}, {14'h0, r[4:3]});
      chk({15'h0, pwr}, {15'h0, r[5]});
      wr(8'h00, 16'hffff);
      rd(8'h00, 16'h1fbf);
      wr(8'h00, 16'h0483);
      wbusy();
      chk({15'h0, got}, 16'h0000);
      $display("test fields done");
      wr(8'h00, 16'h0620);
      @(posedge i_clk);
      chk({15'h0, rdy}, 16'h0000);
      repeat (8) @(posedge i_clk);
      chk({15'h0, rdy}, 16'h0001);
      rd(8'h04, 16'h0005);
      $display("test power done");
      for (int d = 0; d < 6; d++) begin
         for (int a = 0; a < 4; a++) begin
            single(d[2:0], a[1:0], (d < 2) && a[0]);
         end
      end
      $display("test divide done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, 16'h0420 | ((i == 3) ? 16'h0005 : 16'(i)));
         pulse(4'(1 << i));
         wbusy();
         chk({15'h0, got}, 16'h0000);
         wr(8'h00, 16'h04a0 | ((i == 3) ? 16'h0005 : 16'(i)));
         pulse(4'(1 << i));
         wdone();
      end
      wr(8'h00, 16'h04a6);
      pulse(4'hf);
      wbusy();
      chk({15'h0, got}, 16'h0000);
      $display("test triggers done");
      wr(8'h00, 16'h04a4);
      wdone();
      wr(8'h00, 16'h0424);
      rd(8'h04, 16'h000f);
      wdone();
      wdone();
      wr(8'h00, 16'h0400);
      repeat (2) @(posedge i_clk);
      chk({15'h0, pwr}, 16'h0000);
      $display("test continuous done");
      wrap_up();
   end
endmodule
